// ---- core/irq_pkg.sv ----
/*
  Shared constants, types and helper functions for the vectored interrupt
  controller and its free-running timer.
  Assumes a single 10 MHz system clock and a processor core that takes
  vectored requests through a request and acknowledge handshake.
*/
// Operation
// - Seven maskable sources, each with own vector.
// - Sources: bus reset, taps, endpoints, wake, GPIO.
// - Timer taps interrupt periodically, no re-arming.
// - Endpoint interrupt only after transaction finishes.
// - Per-pin mask gates the combined GPIO request.
// - Per-pin polarity picks rising or falling edge.
// - Twelve-bit counter runs continuously at 1 MHz.
// - Counter supplies 128 us and 1.024 ms taps.
// - Counter readable anytime without disturbing count.
// - PS/2 line activity start raises an interrupt.
// - Acknowledge disables interrupts; return re-enables them.
package irq_pkg;

  // System clock and the timer tick rate.
  localparam int CLK_HZ        = 10_000_000;
  localparam int TICK_HZ       = 1_000_000;
  localparam int TICK_DIV      = CLK_HZ / TICK_HZ;

  // Timer geometry and tap periods, in nanoseconds and then in ticks.
  localparam int TIMER_W       = 12;
  localparam int TICK_NS       = 1_000_000_000 / TICK_HZ;
  localparam int TAP_FAST_NS   = 128_000;
  localparam int TAP_SLOW_NS   = 1_024_000;
  localparam int TAP_FAST_TICK = TAP_FAST_NS / TICK_NS;
  localparam int TAP_SLOW_TICK = TAP_SLOW_NS / TICK_NS;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 12'h000;

  // Interrupt sources and vectors.
  localparam int NUM_SRC       = 7;
  localparam int VEC_W         = 14;
  localparam logic [VEC_W-1:0] VEC_BASE = 14'h0004;
  localparam logic [VEC_W-1:0] VEC_STEP = 14'h0002;
  localparam logic GIE_RESET   = 1'b0;

  // GPIO port width and the settling time of the pin filters after reset.
  localparam int GPIO_W        = 10;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // One bit per source; bus reset sits in bit 0 and has top priority.
  typedef struct packed {
    logic gpio;
    logic wake;
    logic ep1;
    logic ep0;
    logic tap_slow;
    logic tap_fast;
    logic bus_reset;
  } irq_src_t;

  typedef enum logic [2:0] {
    ID_BUS_RESET = 3'h0,
    ID_TAP_FAST  = 3'h1,
    ID_TAP_SLOW  = 3'h2,
    ID_EP0       = 3'h3,
    ID_EP1       = 3'h4,
    ID_WAKE      = 3'h5,
    ID_GPIO      = 3'h6
  } irq_id_t;

  // Entry address of a source.
  function automatic logic [VEC_W-1:0] vector_of(input irq_id_t id);
    vector_of = VEC_BASE + VEC_STEP * {11'h000, id};
  endfunction : vector_of

  // Lowest set bit wins.
  function automatic irq_id_t pick_first(input logic [NUM_SRC-1:0] v);
    pick_first = ID_BUS_RESET;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick_first = irq_id_t'(i[2:0]);
      end
    end
  endfunction : pick_first

  // Bits of higher priority than a source.
  function automatic logic [NUM_SRC-1:0] above_mask(input irq_id_t id);
    above_mask = 7'((8'h01 << id) - 8'h01);
  endfunction : above_mask

endpackage : irq_pkg

// ---- core/free_timer.sv ----
/*
  Free-running timer: a prescaler turns the system clock into a 1 MHz
  tick, a counter advances on each tick, and two taps pulse on wrap of
  their low bits.
  Assumes the tap periods are powers of two no larger than the counter.
*/
`timescale 1ns/1ns
module free_timer
  import irq_pkg::*;
#(
  parameter int TW  = TIMER_W,
  parameter int DIV = TICK_DIV
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  output logic [TW-1:0]      count,
  output logic               tap_fast,
  output logic               tap_slow
);

  localparam logic [TW-1:0] FAST_MASK = TW'(TAP_FAST_TICK - 1);
  localparam logic [TW-1:0] SLOW_MASK = TW'(TAP_SLOW_TICK - 1);
  localparam logic [7:0]    DIV_LAST  = 8'(DIV - 1);

  logic [7:0] pre;
  logic       tick;

  assign tick = (pre == DIV_LAST);

  // Prescaler from the system clock down to the timer tick.
  always_ff @(posedge clk) begin
    if (rst) begin
      pre <= 8'h00;
    end else if (ce) begin
      pre <= tick ? 8'h00 : pre + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= TIMER_RESET;
    end else if (ce && tick) begin
      count <= count + TW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tap_fast <= 1'b0;
      tap_slow <= 1'b0;
    end else if (ce) begin
      tap_fast <= tick && ((count & FAST_MASK) == FAST_MASK);
      tap_slow <= tick && ((count & SLOW_MASK) == SLOW_MASK);
    end
  end

  a_count_steps: assert property (@(posedge clk) disable iff (rst)
    ce && tick |=> count == $past(count) + TW'(1))
    else $error("timer did not advance on its tick");

  a_fast_period: assert property (@(posedge clk) disable iff (rst)
    $rose(tap_fast) |-> ((count & FAST_MASK) == '0) && $past(ce && tick))
    else $error("fast tap pulsed off its wrap");

  a_slow_period: assert property (@(posedge clk) disable iff (rst)
    $rose(tap_slow) |-> ((count & SLOW_MASK) == '0) && $past(ce && tick))
    else $error("slow tap pulsed off its wrap");

endmodule : free_timer

// ---- core/edge_irq.sv ----
/*
  Edge interrupt from a group of asynchronous pins: three-stage
  synchronisers with agreement filter, per-pin polarity and mask, and one
  combined request pulse.
  Assumes pins may change at any time relative to the clock.
*/
`timescale 1ns/1ns
module edge_irq
  import irq_pkg::*;
#(
  parameter int W = GPIO_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic [W-1:0]  pin,
  input  wire logic [W-1:0]  mask,
  input  wire logic [W-1:0]  rising,
  output logic               req
);

  // The level and edge stages fill two cycles after the sync chain, so the
  // settle window covers them too; otherwise a pin that idles high gives a
  // false rising edge right after reset.
  localparam logic [2:0] SETTLE_END = 3'(SETTLE_CYCLES) + 3'h2;

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] sync3;
  logic [W-1:0] level;
  logic [W-1:0] level_d;
  logic [2:0]   settle;
  logic [W-1:0] trig;

  // Three flip-flops; only the second and third are compared.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (ce) begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A pin level is accepted once two stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      level   <= '0;
      level_d <= '0;
    end else if (ce) begin
      level   <= (sync2 & sync3) | (level & (sync2 | sync3));
      level_d <= level;
    end
  end

  // Edges are ignored until the filter has seen the pins after reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      settle <= 3'h0;
    end else if (ce && settle != SETTLE_END) begin
      settle <= settle + 3'h1;
    end
  end

  assign trig = (rising & level & ~level_d) | (~rising & ~level & level_d);

  always_ff @(posedge clk) begin
    if (rst) begin
      req <= 1'b0;
    end else if (ce) begin
      req <= (settle == SETTLE_END) && ((trig & mask) != '0);
    end
  end

  a_mask_blocks: assert property (@(posedge clk) disable iff (rst)
    req && $past(ce) |-> $past((trig & mask) != '0))
    else $error("request raised without an enabled pin edge");

  a_polarity_edge: assert property (@(posedge clk) disable iff (rst)
    req && $past(ce) |-> $past(((mask & rising & level & ~level_d)
                               | (mask & ~rising & ~level & level_d)) != '0))
    else $error("request raised by the wrong edge polarity");

endmodule : edge_irq

// ---- core/vect_irq_ctrl.sv ----
/*
  Vectored interrupt controller with its free-running timer. Seven
  sources latch into pending bits; the enabled pending source of highest
  priority is offered to the core with its entry address while the global
  enable is set. Acknowledge clears that pending bit and the global enable;
  the return from the service routine sets the enable again.
  Assumes USB engine, wake-up timer and core signals share CLK_SYS, and
  that GPIO and PS/2 lines are asynchronous pins.
  Pending bits latch even while their source is disabled, so a source
  that is enabled later is offered at once if it fired before.
*/
`timescale 1ns/1ns
module vect_irq_ctrl
  import irq_pkg::*;
#(
  parameter int GPIO_PINS = GPIO_W
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic                  USB_BUS_RESET,
  input  wire logic                  EP0_BUSY,
  input  wire logic                  EP1_BUSY,
  input  wire logic                  WAKE_TICK,
  input  wire logic [GPIO_PINS-1:0]  GPIO_PIN,
  input  wire logic [GPIO_PINS-1:0]  GPIO_MASK,
  input  wire logic [GPIO_PINS-1:0]  GPIO_RISING,
  input  wire logic                  PS2_MODE,
  input  wire logic                  PS2_SCLK,
  input  wire logic                  PS2_SDATA,
  input  irq_pkg::irq_src_t          IRQ_ENABLE,
  input  wire logic                  INT_ON,
  input  wire logic                  INT_OFF,
  input  wire logic                  IRQ_ACK,
  input  wire logic                  RETI_DONE,
  output logic                       IRQ_REQ,
  output irq_pkg::irq_id_t           IRQ_SOURCE,
  output logic [irq_pkg::VEC_W-1:0]  IRQ_VECTOR,
  output irq_pkg::irq_src_t          IRQ_PENDING,
  output logic                       INT_ENABLED,
  output logic [irq_pkg::TIMER_W-1:0] TIMER_VALUE
);

  logic [TIMER_W-1:0] timer_count;
  logic               tap_fast;
  logic               tap_slow;
  logic               gpio_req;
  logic               ps2_req;
  logic [1:0]         ep_busy_d;
  logic [1:0]         ep_done;
  irq_src_t           events;
  irq_src_t           clear_bits;
  irq_src_t           next_pending;
  logic               take;
  logic               next_gie;
  logic               next_req;
  logic [NUM_SRC-1:0] pend_vec;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] live;

  assign pend_vec = IRQ_PENDING;
  assign en_vec   = IRQ_ENABLE;

  // The 1 MHz counter and its two periodic taps.
  free_timer #(
    .TW  (TIMER_W),
    .DIV (TICK_DIV)
  ) u_timer (
    .clk      (CLK_SYS),
    .rst      (RST),
    .ce       (CE),
    .count    (timer_count),
    .tap_fast (tap_fast),
    .tap_slow (tap_slow)
  );

  assign TIMER_VALUE = timer_count;

  // Port pins with per-pin mask and polarity, folded into one request.
  edge_irq #(
    .W (GPIO_PINS)
  ) u_gpio (
    .clk    (CLK_SYS),
    .rst    (RST),
    .ce     (CE),
    .pin    (GPIO_PIN),
    .mask   (GPIO_MASK),
    .rising (GPIO_RISING),
    .req    (gpio_req)
  );

  edge_irq #(
    .W (2)
  ) u_ps2 (
    .clk    (CLK_SYS),
    .rst    (RST),
    .ce     (CE),
    .pin    ({PS2_SCLK, PS2_SDATA}),
    .mask   ({2{PS2_MODE}}),
    .rising (2'h0),
    .req    (ps2_req)
  );

  // Endpoint busy levels are delayed once to find their falling edge.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ep_busy_d <= 2'h0;
    end else if (CE) begin
      ep_busy_d <= {EP1_BUSY, EP0_BUSY};
    end
  end

  assign ep_done = ep_busy_d & ~{EP1_BUSY, EP0_BUSY};

  always_comb begin
    events           = '0;
    events.bus_reset = PS2_MODE ? ps2_req : USB_BUS_RESET;
    events.tap_fast  = tap_fast;
    events.tap_slow  = tap_slow;
    events.ep0       = ep_done[0];
    events.ep1       = ep_done[1];
    events.wake      = WAKE_TICK;
    events.gpio      = gpio_req;
  end

  // The core takes the offered request only while it is being offered.
  assign take = CE && IRQ_ACK && IRQ_REQ;

  always_comb begin
    clear_bits = '0;
    if (take) begin
      clear_bits = irq_src_t'(7'h01 << IRQ_SOURCE);
    end
    // A new event in the acknowledge cycle keeps its bit set.
    next_pending = (IRQ_PENDING & ~clear_bits) | events;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ_PENDING <= '0;
    end else if (CE) begin
      IRQ_PENDING <= next_pending;
    end
  end

  always_comb begin
    next_gie = INT_ENABLED;
    if (take) begin
      next_gie = 1'b0;
    end else if (INT_OFF) begin
      next_gie = 1'b0;
    end else if (RETI_DONE || INT_ON) begin
      next_gie = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      INT_ENABLED <= GIE_RESET;
    end else if (CE) begin
      INT_ENABLED <= next_gie;
    end
  end

  assign live     = next_pending & en_vec;
  assign next_req = next_gie && (live != '0);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ_REQ    <= 1'b0;
      IRQ_SOURCE <= ID_BUS_RESET;
      IRQ_VECTOR <= vector_of(ID_BUS_RESET);
    end else if (CE) begin
      IRQ_REQ    <= next_req;
      IRQ_SOURCE <= pick_first(live);
      IRQ_VECTOR <= vector_of(pick_first(live));
    end
  end

  a_ack_disables: assert property (@(posedge CLK_SYS) disable iff (RST)
    take |=> !INT_ENABLED && !IRQ_REQ)
    else $error("acknowledge left interrupts enabled");

  a_reti_enables: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && RETI_DONE && !INT_OFF && !take |=> INT_ENABLED)
    else $error("return did not re-enable interrupts");

  a_req_gated: assert property (@(posedge CLK_SYS) disable iff (RST)
    IRQ_REQ |-> INT_ENABLED && pend_vec[IRQ_SOURCE])
    else $error("request offered while disabled or not pending");

  a_vector_match: assert property (@(posedge CLK_SYS) disable iff (RST)
    IRQ_REQ |-> IRQ_VECTOR == vector_of(IRQ_SOURCE))
    else $error("vector does not match the offered source");

  a_mask_source: assert property (@(posedge CLK_SYS) disable iff (RST)
    IRQ_REQ && $past(CE) |-> (($past(en_vec) >> IRQ_SOURCE) & 7'h01) != 7'h00)
    else $error("disabled source was offered");

  // pending bits only fall on acknowledge.
  a_pend_sticky: assert property (@(posedge CLK_SYS) disable iff (RST)
    !$past(RST) && (($past(pend_vec) & ~pend_vec) != '0) |-> $past(take))
    else $error("pending bit dropped without acknowledge");

  a_prio_fixed: assert property (@(posedge CLK_SYS) disable iff (RST)
    IRQ_REQ && $past(CE) |->
      ((pend_vec & $past(en_vec) & above_mask(IRQ_SOURCE)) == '0))
    else $error("a higher priority request was passed over");

  a_ep_after_busy: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(IRQ_PENDING.ep0) |-> $past(ep_busy_d[0] && !EP0_BUSY))
    else $error("endpoint interrupt raised during its transaction");

  // bus reset source follows the mode.
  a_ps2_source: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(IRQ_PENDING.bus_reset) |-> $past(PS2_MODE ? ps2_req : USB_BUS_RESET))
    else $error("bus reset source pended from the wrong mode");

  a_tap_pends: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && tap_fast |=> IRQ_PENDING.tap_fast)
    else $error("fast tap did not pend");

  a_slow_tap_pends: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && tap_slow |=> IRQ_PENDING.tap_slow)
    else $error("slow tap did not pend");

  a_wake_pends: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && WAKE_TICK |=> IRQ_PENDING.wake)
    else $error("wake-up tick did not pend");

  // bus reset pends in USB mode.
  a_usb_reset_pends: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && !PS2_MODE && USB_BUS_RESET |=> IRQ_PENDING.bus_reset)
    else $error("bus reset did not pend");

  a_ep_done_pends: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && (ep_done != 2'h0) |=>
      (({IRQ_PENDING.ep1, IRQ_PENDING.ep0} & $past(ep_done)) == $past(ep_done)))
    else $error("endpoint completion did not pend");

  // second endpoint pends after busy ends.
  a_ep1_after_busy: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(IRQ_PENDING.ep1) |-> $past(ep_busy_d[1] && !EP1_BUSY))
    else $error("second endpoint interrupt raised during its transaction");

  a_gpio_pends: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && gpio_req |=> IRQ_PENDING.gpio)
    else $error("port request did not pend");

  a_off_wins: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && INT_OFF |=> !INT_ENABLED)
    else $error("disable pulse left interrupts enabled");

  a_on_enables: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && INT_ON && !INT_OFF && !take |=> INT_ENABLED)
    else $error("enable pulse did not set the global enable");

  a_req_offered: assert property (@(posedge CLK_SYS) disable iff (RST)
    INT_ENABLED && $past(CE) && ((pend_vec & $past(en_vec)) != '0) |-> IRQ_REQ)
    else $error("enabled pending source was not offered");

  a_ack_clears: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && ((events & clear_bits) == '0) |=> ((pend_vec & $past(clear_bits)) == '0))
    else $error("acknowledged bit stayed pending");

  a_set_wins: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && ((events & clear_bits) != '0) |=> ((pend_vec & $past(clear_bits)) != '0))
    else $error("event in the acknowledge cycle was lost");

  // pending bits rise only on events.
  a_pend_from_event: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((pend_vec & ~$past(pend_vec) & ~$past(events)) == '0))
    else $error("pending bit set without an event");

  a_pend_frozen: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CE |=> $stable(IRQ_PENDING))
    else $error("pending bits changed while the clock enable was low");

endmodule : vect_irq_ctrl

// ---- tb/core_model.sv ----
/*
  Processor core stand-in: accepts an offered request, services it for a
  short or long time, then signals the return from the service routine.
  Assumes the request outputs are registered on the same clock.
*/
`timescale 1ns/1ns
module core_model
  import irq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        auto,
  input  wire logic        slow,
  input  wire logic        req,
  input  irq_pkg::irq_id_t source,
  output logic             ack,
  output logic             reti,
  output irq_pkg::irq_id_t last_id,
  output int               n_ack
);
  import irq_pkg::*;

  logic       busy;
  logic [3:0] cnt;

  // Acknowledge one request, hold it one cycle, then return after service.
  // ack then return
  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
      reti <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
      last_id <= ID_BUS_RESET;
      n_ack <= 0;
    end else begin
      reti <= 1'b0;
      if (ack) begin
        ack <= 1'b0;
        busy <= 1'b1;
        last_id <= source;
        n_ack <= n_ack + 1;
        cnt <= slow ? 4'h8 : 4'h1;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          busy <= 1'b0;
          reti <= 1'b1;
        end
      end else if (auto && req) begin
        ack <= 1'b1;
      end
    end
  end
endmodule : core_model

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the vectored interrupt controller.
  Assumes a 10 MHz clock and the core stand-in answering the handshake.
*/
`timescale 1ns/1ns
module tb_top;
  import irq_pkg::*;
  typedef struct packed { logic [2:0] kind; irq_id_t id; } row_t;
  logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, usb_bus_reset = 1'b0;
  logic        ep0_busy = 1'b0, ep1_busy = 1'b0, wake_tick = 1'b0, ps2_mode = 1'b0;
  logic        ps2_sclk = 1'b1, ps2_sdata = 1'b1, int_on = 1'b0, int_off = 1'b0;
  logic        auto = 1'b0, slow = 1'b0, irq_req, int_enabled, irq_ack, reti_done;
  logic [9:0]  gpio_pin = 10'h001, gpio_mask = 10'h000, gpio_rising = 10'h3FE;
  irq_src_t    irq_enable = irq_src_t'(7'h00), irq_pending;
  irq_id_t     irq_source, last_id;
  logic [13:0] irq_vector;
  logic [11:0] timer_value;
  logic [6:0]  pend;
  int          n_ack, cyc = 0, err_count = 0, n_tests = 0, k;
  row_t        rows [7] = '{'{3'h0, ID_BUS_RESET}, '{3'h1, ID_WAKE}, '{3'h2, ID_EP0},
                            '{3'h3, ID_EP1}, '{3'h4, ID_GPIO}, '{3'h5, ID_BUS_RESET},
                            '{3'h6, ID_GPIO}};

  assign pend = irq_pending;

  // Clock and a cycle count for period measurement.
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  vect_irq_ctrl dut_u (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .USB_BUS_RESET(usb_bus_reset),
    .EP0_BUSY(ep0_busy), .EP1_BUSY(ep1_busy), .WAKE_TICK(wake_tick), .GPIO_PIN(gpio_pin),
    .GPIO_MASK(gpio_mask), .GPIO_RISING(gpio_rising), .PS2_MODE(ps2_mode),
    .PS2_SCLK(ps2_sclk), .PS2_SDATA(ps2_sdata), .IRQ_ENABLE(irq_enable), .INT_ON(int_on),
    .INT_OFF(int_off), .IRQ_ACK(irq_ack), .RETI_DONE(reti_done), .IRQ_REQ(irq_req),
    .IRQ_SOURCE(irq_source), .IRQ_VECTOR(irq_vector), .IRQ_PENDING(irq_pending),
    .INT_ENABLED(int_enabled), .TIMER_VALUE(timer_value));

  core_model core_u (.clk(clk_sys), .rst(rst), .auto(auto), .slow(slow), .req(irq_req),
    .source(irq_source), .ack(irq_ack), .reti(reti_done), .last_id(last_id), .n_ack(n_ack));

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Raises one kind of source event.
  task automatic fire(input logic [2:0] kind);
    @(posedge clk_sys);
    case (kind)
      3'h0: usb_bus_reset <= 1'b1;
      3'h1: wake_tick <= 1'b1;
      3'h2: ep0_busy <= 1'b1;
      3'h3: ep1_busy <= 1'b1;
      3'h4: begin
        gpio_mask <= 10'h008;
        gpio_pin[3] <= 1'b1;
      end
      3'h5: begin
        ps2_mode <= 1'b1;
        ps2_sdata <= 1'b0;
      end
      default: begin
        gpio_mask <= 10'h001;
        gpio_pin[0] <= 1'b0;
      end
    endcase
    @(posedge clk_sys);
    usb_bus_reset <= 1'b0;
    wake_tick <= 1'b0;
    if (kind == 3'h2 || kind == 3'h3) begin
      repeat (3) @(posedge clk_sys);
      #1;
      chk(pend[kind + 3'h1], 1'b0);
      @(posedge clk_sys);
      ep0_busy <= 1'b0;
      ep1_busy <= 1'b0;
    end
  endtask : fire

  // Measures the spacing of two timer tap pendings.
  task automatic tap(input irq_id_t id, input int p);
    int t0;
    @(posedge clk_sys);
    irq_enable <= irq_src_t'(7'h01 << id);
    #1;
    repeat (40) if (pend[id] !== 1'b0) begin @(posedge clk_sys); #1; end
    repeat (p + 40) if (pend[id] !== 1'b1) begin @(posedge clk_sys); #1; end
    t0 = cyc;
    repeat (40) if (pend[id] !== 1'b0) begin @(posedge clk_sys); #1; end
    repeat (p + 40) if (pend[id] !== 1'b1) begin @(posedge clk_sys); #1; end
    chk(16'(cyc - t0), 16'(p));
    $display("tap %0d done", id);
  endtask : tap

  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk({irq_req, int_enabled, pend}, 9'h000);
    chk(irq_vector, VEC_BASE);
    chk(timer_value, 12'h000);
    k = timer_value;
    repeat (100) @(posedge clk_sys);
    #1;
    chk(timer_value - k[11:0], 12'h00A);
    @(posedge clk_sys);
    int_on <= 1'b1;
    @(posedge clk_sys);
    int_on <= 1'b0;
    $display("reset done");
    // Each source other than the two timer taps alone: offer, vector, acknowledge and return.
    foreach (rows[i]) begin
      @(posedge clk_sys);
      auto <= 1'b0;
      ps2_mode <= 1'b0;
      ps2_sdata <= 1'b1;
      irq_enable <= irq_src_t'(7'h01 << rows[i].id);
      fire(rows[i].kind);
      #1;
      repeat (12) if (irq_req !== 1'b1) begin @(posedge clk_sys); #1; end
      chk(irq_req, 1'b1);
      chk(irq_source, rows[i].id);
      chk(irq_vector, VEC_BASE + VEC_STEP * rows[i].id);
      k = n_ack;
      @(posedge clk_sys);
      auto <= 1'b1;
      repeat (20) if (n_ack == k) begin @(posedge clk_sys); #1; end
      chk(last_id, rows[i].id);
      repeat (20) if (int_enabled !== 1'b1) begin @(posedge clk_sys); #1; end
      chk(pend[rows[i].id], 1'b0);
      $display("row %0d done", i);
    end
    // Masked pin and wrong edge give no request.
    @(posedge clk_sys);
    auto <= 1'b0;
    gpio_mask <= 10'h008;
    gpio_pin[5] <= 1'b1;
    gpio_pin[3] <= 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    chk(pend[6], 1'b0);
    $display("gpio filter done");
    // Two sources at once with the global enable off, then priority order.
    @(posedge clk_sys);
    auto <= 1'b0;
    ps2_mode <= 1'b0;
    int_off <= 1'b1;
    irq_enable <= irq_src_t'(7'h21);
    @(posedge clk_sys);
    int_off <= 1'b0;
    usb_bus_reset <= 1'b1;
    wake_tick <= 1'b1;
    @(posedge clk_sys);
    usb_bus_reset <= 1'b0;
    wake_tick <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(irq_req, 1'b0);
    chk({pend[5], pend[0]}, 2'h3);
    @(posedge clk_sys);
    int_on <= 1'b1;
    auto <= 1'b1;
    k = n_ack;
    @(posedge clk_sys);
    int_on <= 1'b0;
    repeat (10) if (n_ack == k) begin @(posedge clk_sys); #1; end
    chk({int_enabled, irq_req, pend[0], pend[5]}, 4'h1);
    chk(last_id, ID_BUS_RESET);
    repeat (20) if (n_ack == k + 1) begin @(posedge clk_sys); #1; end
    chk(last_id, ID_WAKE);
    $display("priority done");
    slow <= 1'b1;
    tap(ID_TAP_FAST, 1280);
    tap(ID_TAP_SLOW, 10240);
    // Clock enable low holds the count.
    @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    #1;
    k = timer_value;
    repeat (20) @(posedge clk_sys);
    #1;
    chk(timer_value, k[11:0]);
    @(posedge clk_sys);
    ce <= 1'b1;
    rst <= 1'b1;
    gpio_mask <= 10'h020;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk({int_enabled, timer_value}, 13'h0000);
    repeat (10) @(posedge clk_sys);
    #1;
    chk(pend[6], 1'b0);
    $display("freeze and reset done");
    complete_run();
  end
endmodule : tb_top
